// *** verilog/cld_top.v ***
// Design decisions made here: register access over APB and the register offsets.
`include "cld_defines.vh"
`default_nettype none
module cld_top (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Glyph lookup
    input wire [7:0] char_code,
    input wire [2:0] glyph_row,
    input wire cursor_here,
    output reg glyph_user_q,
    output reg [4:0] glyph_pixels_q,
    // Mode and busy outputs
    output reg display_on_q,
    output reg cursor_on_q,
    output reg blink_on_q,
    output reg bus_width_select_q,
    output reg two_line_q,
    output reg font_tall_q,
    output reg busy_flag_q
);
    localparam [31:0] LONG_CYC = `CLD_LONG_CYC;
    localparam [31:0] SHORT_CYC = `CLD_SHORT_CYC;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_CLEAR = 3'h2;
    localparam [2:0] ST_WAIT = 3'h4;
    // Instruction kinds, named by the highest set bit of the byte
    localparam [3:0] CMD_NONE = 4'h0;
    localparam [3:0] CMD_CLEAR = 4'h1;
    localparam [3:0] CMD_HOME = 4'h2;
    localparam [3:0] CMD_ENTRY = 4'h3;
    localparam [3:0] CMD_ONOFF = 4'h4;
    localparam [3:0] CMD_SHIFT = 4'h5;
    localparam [3:0] CMD_FUNC = 4'h6;
    localparam [3:0] CMD_GADDR = 4'h7;
    localparam [3:0] CMD_DADDR = 4'h8;

    reg [2:0] state_q;
    reg [15:0] busy_cnt_q;
    reg [6:0] address_counter_q;
    reg glyph_sel_q;
    reg entry_inc_q;
    reg entry_shift_q;
    reg [6:0] shift_q;
    reg [7:0] data_holding_reg_q;
    reg [6:0] clr_ptr_q;
    reg [7:0] dram [0:`CLD_DRAM_WORDS-1];

    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire [7:0] wbyte = pwdata[7:0];
    wire instr_wr = wr & (paddr == `CLD_ADDR_INSTR);
    wire data_wr = wr & (paddr == `CLD_ADDR_DATA);
    wire data_rd = rd & (paddr == `CLD_ADDR_DATA);
    wire data_acc = data_wr | data_rd;
    wire known = (paddr == `CLD_ADDR_STATUS) | (paddr == `CLD_ADDR_INSTR) | (paddr == `CLD_ADDR_DATA) |
                 (paddr == `CLD_ADDR_MODE) | (paddr == `CLD_ADDR_GLYPH) | (paddr == `CLD_ADDR_SHIFT);
    // Instruction and data access while busy is ignored, not errored
    wire take = ~busy_flag_q;
    wire glyph_wr = data_wr & take & glyph_sel_q;
    wire [7:0] glyph_rd;
    wire g_user;
    wire [4:0] g_pix;
    wire [3:0] cmd;

    // Step after a RAM access, used for data and cursor shift
    function [6:0] step;
        input [6:0] a;
        input up;
        input g;
        reg [6:0] n;
        begin
            n = up ? a + 7'h01 : a - 7'h01;
            step = g ? {1'b0, n[5:0]} : n;
        end
    endfunction

    // Display offset moves one column; wraps like the hardware counter
    function [6:0] offset_step;
        input [6:0] s;
        input right;
        begin
            offset_step = right ? s + 7'h01 : s - 7'h01;
        end
    endfunction

    // Bits below a command's fields are don't-care
    function [3:0] instr_kind;
        input [7:0] b;
        begin
            if (b[7]) begin
                instr_kind = CMD_DADDR;
            end else if (b[6]) begin
                instr_kind = CMD_GADDR;
            end else if (b[5]) begin
                instr_kind = CMD_FUNC;
            end else if (b[4]) begin
                instr_kind = CMD_SHIFT;
            end else if (b[3]) begin
                instr_kind = CMD_ONOFF;
            end else if (b[2]) begin
                instr_kind = CMD_ENTRY;
            end else if (b[1]) begin
                instr_kind = CMD_HOME;
            end else if (b[0]) begin
                instr_kind = CMD_CLEAR;
            end else begin
                instr_kind = CMD_NONE;
            end
        end
    endfunction

    assign cmd = instr_kind(wbyte);

    cld_glyph_ram u_glyph (
        .clk(clk),
        .wr_en(glyph_wr),
        .wr_addr(address_counter_q[5:0]),
        .wr_data(wbyte),
        .rd_addr(address_counter_q[5:0]),
        .rd_data(glyph_rd),
        .char_code(char_code),
        .row(glyph_row),
        .cursor_on(cursor_here),
        .is_user(g_user),
        .pixels(g_pix)
    );

    always @(posedge clk) begin
        if (state_q == ST_CLEAR) begin
            dram[clr_ptr_q] <= `CLD_SPACE;
        end else if (data_wr & take & ~glyph_sel_q) begin
            dram[address_counter_q] <= wbyte;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            busy_cnt_q <= 16'h0000;
            busy_flag_q <= 1'b0;
            address_counter_q <= 7'h00;
            glyph_sel_q <= 1'b0;
            entry_inc_q <= 1'b1;
            entry_shift_q <= 1'b0;
            shift_q <= 7'h00;
            data_holding_reg_q <= 8'h00;
            clr_ptr_q <= 7'h00;
            display_on_q <= 1'b0;
            cursor_on_q <= 1'b0;
            blink_on_q <= 1'b0;
            bus_width_select_q <= 1'b1;
            two_line_q <= 1'b0;
            font_tall_q <= 1'b0;
            glyph_user_q <= 1'b0;
            glyph_pixels_q <= 5'h00;
        end else begin
            glyph_user_q <= g_user;
            glyph_pixels_q <= g_pix;
            case (state_q)
                ST_IDLE: begin
                    if (instr_wr & take) begin
                        busy_flag_q <= 1'b1;
                        state_q <= ST_WAIT;
                        busy_cnt_q <= SHORT_CYC[15:0] - 16'h0001;
                        // Highest set bit picks the instruction
                        case (cmd)
                            CMD_DADDR: begin
                                address_counter_q <= wbyte[6:0];
                                glyph_sel_q <= 1'b0;
                            end
                            CMD_GADDR: begin
                                address_counter_q <= {1'b0, wbyte[5:0]};
                                glyph_sel_q <= 1'b1;
                            end
                            CMD_FUNC: begin
                                // Width bit only stored: one byte per transfer here
                                bus_width_select_q <= wbyte[4];
                                two_line_q <= wbyte[3];
                                font_tall_q <= wbyte[2];
                            end
                            CMD_SHIFT: begin
                                if (wbyte[3]) begin
                                    shift_q <= offset_step(shift_q, wbyte[2]);
                                end else begin
                                    address_counter_q <= step(address_counter_q, wbyte[2], glyph_sel_q);
                                end
                            end
                            CMD_ONOFF: begin
                                display_on_q <= wbyte[2];
                                cursor_on_q <= wbyte[1];
                                blink_on_q <= wbyte[0];
                            end
                            CMD_ENTRY: begin
                                entry_inc_q <= wbyte[1];
                                entry_shift_q <= wbyte[0];
                            end
                            CMD_HOME: begin
                                address_counter_q <= 7'h00;
                                glyph_sel_q <= 1'b0;
                                shift_q <= 7'h00;
                                busy_cnt_q <= LONG_CYC[15:0] - 16'h0001;
                            end
                            CMD_CLEAR: begin
                                address_counter_q <= 7'h00;
                                glyph_sel_q <= 1'b0;
                                shift_q <= 7'h00;
                                entry_inc_q <= 1'b1;
                                clr_ptr_q <= 7'h00;
                                state_q <= ST_CLEAR;
                                busy_cnt_q <= LONG_CYC[15:0] - 16'h0001;
                            end
                            default: begin
                                state_q <= ST_WAIT;
                            end
                        endcase
                    end else if (data_acc & take) begin
                        busy_flag_q <= 1'b1;
                        state_q <= ST_WAIT;
                        busy_cnt_q <= SHORT_CYC[15:0] - 16'h0001;
                        if (data_rd) begin
                            data_holding_reg_q <= glyph_sel_q ? glyph_rd : dram[address_counter_q];
                        end
                        address_counter_q <= step(address_counter_q, entry_inc_q, glyph_sel_q);
                        if (data_wr & entry_shift_q & ~glyph_sel_q) begin
                            // Increment shifts left, per entry rule
                            shift_q <= offset_step(shift_q, ~entry_inc_q);
                        end
                    end
                end
                ST_CLEAR: begin
                    clr_ptr_q <= clr_ptr_q + 7'h01;
                    busy_cnt_q <= busy_cnt_q - 16'h0001;
                    if (clr_ptr_q == 7'h7F) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (busy_cnt_q == 16'h0000) begin
                        busy_flag_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        busy_cnt_q <= busy_cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_flag_q <= 1'b0;
                end
            endcase
        end
    end

    // Single-wait-state slave: ready in the second cycle of every access phase
    wire ready_d = psel & penable & ~pready;
    wire [31:0] mode_word = {20'h00000, bus_width_select_q, two_line_q, font_tall_q,
                             display_on_q, cursor_on_q, blink_on_q, entry_inc_q,
                             entry_shift_q, glyph_sel_q, 3'h0};
    reg [31:0] rdata_d;

    // Read data stays zero outside the answer cycle, so a late sample shows nothing stale
    always @* begin
        rdata_d = 32'h00000000;
        if (ready_d & ~pwrite) begin
            case (paddr)
                `CLD_ADDR_STATUS: begin
                    rdata_d = {24'h000000, busy_flag_q, address_counter_q};
                end
                `CLD_ADDR_DATA: begin
                    rdata_d = {24'h000000, data_holding_reg_q};
                end
                `CLD_ADDR_MODE: begin
                    rdata_d = mode_word;
                end
                `CLD_ADDR_SHIFT: begin
                    rdata_d = {25'h0000000, shift_q};
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= ready_d;
            pslverr <= ready_d & ~known;
            prdata <= rdata_d;
        end
    end
endmodule // cld_top
`default_nettype wire

// *** include/cld_defines.vh ***
// Function
// - Character code low three bits form glyph RAM address bits 3 to 5.
// - Glyph RAM address bits 0 to 2 select the glyph row.
// - Eighth glyph row shows stored data ORed with the cursor.
// - Row pixels come from data bits 0 to 4, bit 4 leftmost.
// - Codes with bits 7:4 zero select glyph RAM; bit 3 ignored.
// - Clear fills display RAM with spaces, zeroes counter, forces increment.
// - Home zeroes counter and undoes display shift, RAM untouched.
// - Busy 0.76 ms after clear or home, 18.5 us otherwise.
// - Entry direction bit selects counter increment or decrement after access.
// - Glyph RAM accesses step the counter like display RAM.
// - On/off instruction stores display, cursor and blink enables.
// - Shift instruction moves cursor or display, left or right.
// - Function set stores bus width, line count and font bits.
// - Bits 7:6 equal 01 load six-bit glyph RAM address.
// - Bit 7 set loads seven-bit display RAM address.
// - Status read returns busy flag on bit 7, counter below, instantly.
// - Register select high means data write or read of selected RAM.
// - With shift bit set, display RAM writes shift the display.
// - Select and direction pair decode instruction, status, data write, read.
`ifndef CLD_DEFINES_VH
`define CLD_DEFINES_VH
`define CLD_CLK_HZ 40000000
`define CLD_LONG_NS 760000
`define CLD_SHORT_NS 18500
`define CLD_LONG_CYC ((`CLD_LONG_NS * (`CLD_CLK_HZ / 1000000) + 999) / 1000)
`define CLD_SHORT_CYC ((`CLD_SHORT_NS * (`CLD_CLK_HZ / 1000000) + 999) / 1000)
`define CLD_SPACE 8'h20
`define CLD_DRAM_WORDS 128
`define CLD_ADDR_STATUS 12'h000
`define CLD_ADDR_INSTR 12'h004
`define CLD_ADDR_DATA 12'h008
`define CLD_ADDR_MODE 12'h00C
`define CLD_ADDR_GLYPH 12'h010
`define CLD_ADDR_SHIFT 12'h014
`endif

// *** verilog/cld_glyph_ram.v ***
`default_nettype none
module cld_glyph_ram (
    // Clock
    input wire clk,
    // Host port
    input wire wr_en,
    input wire [5:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [5:0] rd_addr,
    output wire [7:0] rd_data,
    // Display lookup
    input wire [7:0] char_code,
    input wire [2:0] row,
    input wire cursor_on,
    output wire is_user,
    output wire [4:0] pixels
);
    reg [7:0] mem [0:63];
    wire [5:0] pix_addr;
    wire [4:0] stored;
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    assign rd_data = mem[rd_addr];
    assign is_user = (char_code[7:4] == 4'h0);
    assign pix_addr = {char_code[2:0], row};
    assign stored = mem[pix_addr][4:0];
    assign pixels = (row == 3'h7) ? (stored | {5{cursor_on}}) : stored;
endmodule // cld_glyph_ram
`default_nettype wire

// *** testbench/cld_checker.sv ***
`default_nettype none
module cld_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Lookup, mode and busy
    input wire logic [7:0] char_code,
    input wire logic glyph_user_q,
    input wire logic display_on_q,
    input wire logic cursor_on_q,
    input wire logic blink_on_q,
    input wire logic busy_flag_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] busy_cnt_q;
    // Length of the last busy stretch, judged when it ends
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) busy_cnt_q <= 16'h0000;
        else busy_cnt_q <= busy_flag_q ? busy_cnt_q + 16'h0001 : 16'h0000;
    sequence s_instr;
        psel && penable && pready && pwrite && paddr == 12'h004 && !busy_flag_q;
    endsequence
    sequence s_onoff;
        s_instr ##0 pwdata[7:3] == 5'h01;
    endsequence
    a_one_wait:
        assert property (psel && $rose(penable) |=> pready) else $error("no answer after one wait");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held");
    a_err_with_ready:
        assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_idle_rdata:
        assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
    a_unmapped_err:
        assert property (psel && $rose(penable) && paddr > 12'h014 |=> pslverr) else $error("unmapped ok");
    a_user_select:
        assert property ($past(rst_n) |-> glyph_user_q == ($past(char_code[7:4]) == 4'h0)) else $error("user sel");
    a_instr_busy:
        assert property (s_instr |-> ##2 busy_flag_q [*8]) else $error("not busy after instruction");
    a_onoff_store:
        assert property (s_onoff |=> {display_on_q, cursor_on_q, blink_on_q} == $past(pwdata[2:0]))
            else $error("on/off bits");
    a_busy_length:
        assert property ($fell(busy_flag_q) |-> busy_cnt_q inside {[16'd720:16'd760], [16'd30380:16'd30420]})
            else $error("busy length");
endmodule // cld_checker
bind cld_top cld_checker u_cld_checker (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .char_code, .glyph_user_q, .display_on_q, .cursor_on_q, .blink_on_q, .busy_flag_q);
`default_nettype wire

// *** testbench/cld_host.sv ***
`default_nettype none
module cld_host (
    // Clock
    input wire logic clk,
    // APB master side
    output var logic psel = 1'b0,
    output var logic penable = 1'b0,
    output var logic pwrite = 1'b0,
    output var logic [11:0] paddr = 12'h000,
    output var logic [31:0] pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 64);
        if (!pready) tb_char_lcd_instruction_decoder.results(1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // A real host never talks to a busy device
    task automatic poll(output logic [31:0] r);
        logic e;
        int n;
        n = 0;
        do begin
            xfer(1'b0, 12'h000, 8'h00, r, e);
            n++;
        end while (r[7] !== 1'b0 && n < 20000);
        if (r[7] !== 1'b0) tb_char_lcd_instruction_decoder.results(1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        poll(r);
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        poll(r);
        xfer(1'b0, a, 8'h00, r, e);
    endtask
endmodule // cld_host
`default_nettype wire

// *** testbench/tb_char_lcd_instruction_decoder.sv ***
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_char_lcd_instruction_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, glyph_user_q, display_on_q, cursor_on_q, blink_on_q, e;
    logic bus_width_select_q, two_line_q, font_tall_q, busy_flag_q;
    logic cursor_here = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] char_code = 8'h00;
    logic [4:0] glyph_pixels_q;
    logic [2:0] glyph_row = 3'h0;
    int bad_count = 0;
    int n_compared = 0;
    logic [7:0] pat [8] = '{8'hEE, 8'h11, 8'h11, 8'h1F, 8'h11, 8'h11, 8'h11, 8'h01};
    always #12.5 clk = ~clk;
    cld_top u_cld_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .char_code, .glyph_row, .cursor_here, .glyph_user_q, .glyph_pixels_q, .display_on_q, .cursor_on_q,
        .blink_on_q, .bus_width_select_q, .two_line_q, .font_tall_q, .busy_flag_q);
    cld_host u_cld_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    task automatic results(input bit tmo);
        bad_count += tmo;
        $display("Compared %0d, errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({bus_width_select_q, display_on_q, busy_flag_q}, 3'h4)
        u_cld_host.wr(12'h004, 8'h2F);
        u_cld_host.wr(12'h004, 8'h0F);
        u_cld_host.wr(12'h004, 8'h06);
        u_cld_host.poll(r);
        `CHK({bus_width_select_q, two_line_q, font_tall_q, display_on_q, cursor_on_q, blink_on_q}, 6'h1F)
        u_cld_host.wr(12'h004, 8'h40);
        for (int i = 0; i < 8; i++) u_cld_host.wr(12'h008, pat[i]);
        u_cld_host.poll(r);
        `CHK(r[7:0], 8'h08)
        // Code 08 aliases glyph 0; last pass puts the cursor on row 7
        for (int i = 0; i < 9; i++) begin
            char_code <= 8'h08;
            glyph_row <= (i == 8) ? 3'h7 : i[2:0];
            cursor_here <= (i == 8);
            repeat (2) @(posedge clk);
            `CHK(glyph_pixels_q, (i == 8) ? 5'h1F : pat[i[2:0]][4:0])
        end
        `CHK(glyph_user_q, 1'b1)
        char_code <= 8'h10;
        repeat (2) @(posedge clk);
        `CHK(glyph_user_q, 1'b0)
        u_cld_host.wr(12'h004, 8'hC5);
        u_cld_host.wr(12'h008, 8'h41);
        u_cld_host.wr(12'h004, 8'h04);
        u_cld_host.wr(12'h008, 8'h42);
        u_cld_host.poll(r);
        `CHK(r[7:0], 8'h45)
        u_cld_host.wr(12'h004, 8'h05);
        u_cld_host.wr(12'h008, 8'h43);
        u_cld_host.rd(12'h014, r);
        `CHK(r[6:0], 7'h01)
        u_cld_host.wr(12'h004, 8'h03);
        u_cld_host.poll(r);
        `CHK(r[7:0], 8'h00)
        u_cld_host.rd(12'h014, r);
        `CHK(r[6:0], 7'h00)
        u_cld_host.wr(12'h004, 8'hC6);
        u_cld_host.rd(12'h008, r);
        u_cld_host.rd(12'h008, r);
        `CHK(r[7:0], 8'h42)
        u_cld_host.rd(12'h014, r);
        `CHK(r[6:0], 7'h00)
        u_cld_host.xfer(1'b1, 12'h004, 8'h90, r, e);
        u_cld_host.xfer(1'b1, 12'h004, 8'hA0, r, e);
        u_cld_host.xfer(1'b0, 12'h000, 8'h00, r, e);
        `CHK(r[7], 1'b1)
        u_cld_host.poll(r);
        `CHK(r[7:0], 8'h10)
        u_cld_host.wr(12'h004, 8'h01);
        u_cld_host.poll(r);
        `CHK(r[7:0], 8'h00)
        u_cld_host.xfer(1'b0, 12'h00C, 8'h00, r, e);
        `CHK(r[5], 1'b1)
        `CHK(r[11:3], 9'h0FE)
        `CHK(e, 1'b0)
        u_cld_host.wr(12'h004, 8'hC6);
        u_cld_host.rd(12'h008, r);
        u_cld_host.rd(12'h008, r);
        `CHK(r[7:0], 8'h20)
        u_cld_host.wr(12'h004, 8'h14);
        u_cld_host.wr(12'h004, 8'h1C);
        u_cld_host.poll(r);
        `CHK(r[7:0], 8'h49)
        u_cld_host.rd(12'h014, r);
        `CHK(r[6:0], 7'h01)
        u_cld_host.xfer(1'b0, 12'h018, 8'h00, r, e);
        `CHK(e, 1'b1)
        results(1'b0);
    end
endmodule // tb_char_lcd_instruction_decoder
`default_nettype wire
